// ---- logic/lfs_pkg.sv ----
// constants and types for the sink b pulse sequencer
package lfs_pkg;
    // register port geometry
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned LEVEL_W       = 8;
    localparam logic [7:0]  CTRL_ADDR     = 8'haf;
    localparam logic [7:0]  STATUS_ADDR   = 8'hf0;
    // control register fields
    localparam int unsigned MODE_BIT      = 15;
    localparam int unsigned TRIG_BIT      = 14;
    localparam int unsigned DRIVE_BIT     = 13;
    localparam int unsigned RATE_BIT      = 12;
    localparam int unsigned DUR_LSB       = 8;
    localparam int unsigned FALL_LSB      = 4;
    localparam int unsigned RISE_LSB      = 0;
    localparam logic [15:0] CTRL_MASK     = 16'hf333;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    // status register fields
    localparam int unsigned STAT_PULSE    = 0;
    localparam int unsigned STAT_ON       = 1;
    localparam int unsigned STAT_LVL_LSB  = 8;
    // clock rate and times in microseconds
    localparam int unsigned CLK_MHZ       = 10;
    localparam int unsigned PULSE_0_US    = 32000;
    localparam int unsigned PULSE_1_US    = 64000;
    localparam int unsigned PULSE_2_US    = 96000;
    localparam int unsigned PULSE_3_US    = 1024000;
    localparam int unsigned LED_RAMP_1_US = 250000;
    localparam int unsigned LED_RAMP_2_US = 500000;
    localparam int unsigned LED_RAMP_3_US = 1000000;
    localparam int unsigned PLS_RAMP_1_US = 1950;
    localparam int unsigned PLS_RAMP_2_US = 3910;
    localparam int unsigned PLS_RAMP_3_US = 7800;
    localparam int unsigned REPEAT_US     = 4000000;
    // times as clock cycles
    localparam int unsigned PULSE_0_CYC   = PULSE_0_US * CLK_MHZ;
    localparam int unsigned PULSE_1_CYC   = PULSE_1_US * CLK_MHZ;
    localparam int unsigned PULSE_2_CYC   = PULSE_2_US * CLK_MHZ;
    localparam int unsigned PULSE_3_CYC   = PULSE_3_US * CLK_MHZ;
    localparam int unsigned LED_RAMP_1_CYC = LED_RAMP_1_US * CLK_MHZ;
    localparam int unsigned LED_RAMP_2_CYC = LED_RAMP_2_US * CLK_MHZ;
    localparam int unsigned LED_RAMP_3_CYC = LED_RAMP_3_US * CLK_MHZ;
    localparam int unsigned PLS_RAMP_1_CYC = PLS_RAMP_1_US * CLK_MHZ;
    localparam int unsigned PLS_RAMP_2_CYC = PLS_RAMP_2_US * CLK_MHZ;
    localparam int unsigned PLS_RAMP_3_CYC = PLS_RAMP_3_US * CLK_MHZ;
    localparam int unsigned REPEAT_CYC    = REPEAT_US * CLK_MHZ;
    // ramp step is the ramp length divided by the level span
    localparam int unsigned RAMP_SHIFT    = 8;
    localparam logic [7:0]  LEVEL_FULL    = 8'hff;
    localparam logic [7:0]  LEVEL_OFF     = 8'h00;
    // pulse sequencer states
    typedef enum logic [0:0] {
        LFS_IDLE  = 1'b0,
        LFS_PULSE = 1'b1
    } lfs_state_t;
endpackage

// ---- logic/lfs_ramp.sv ----
// soft on/off ramp of the sink level
`timescale 1ns/100ps
module lfs_ramp (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_b_i,
    // ramp request
    input  wire logic                        target_i,
    input  wire logic [31:0]                 rise_len_i,
    input  wire logic [31:0]                 fall_len_i,
    // ramp result
    output logic [lfs_pkg::LEVEL_W-1:0]      level_o
);
    import lfs_pkg::*;

    typedef struct packed {
        logic [LEVEL_W-1:0] level;
        logic [31:0]        div_cnt;
    } lfs_ramp_st_t;

    lfs_ramp_st_t s;
    lfs_ramp_st_t next_s;
    logic [31:0]  len;
    logic [31:0]  period;
    logic [7:0]   goal;

    // step the level one count per period toward the goal
    always_comb begin
        next_s = s;
        len    = target_i ? rise_len_i : fall_len_i;
        goal   = target_i ? LEVEL_FULL : LEVEL_OFF;
        period = len >> RAMP_SHIFT;
        if (period == 32'h0000_0000) begin
            period = 32'h0000_0001;
        end
        if (s.level == goal) begin
            next_s.div_cnt = 32'h0000_0000;
        end else if (len == 32'h0000_0000) begin
            next_s.level   = goal;
            next_s.div_cnt = 32'h0000_0000;
        end else if (s.div_cnt + 32'h0000_0001 >= period) begin
            next_s.div_cnt = 32'h0000_0000;
            next_s.level   = target_i ? s.level + 8'h01 : s.level - 8'h01;
        end else begin
            next_s.div_cnt = s.div_cnt + 32'h0000_0001;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.level;

    instant_on_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (target_i && rise_len_i == 32'h0 && s.level != LEVEL_FULL)
        |=> s.level == LEVEL_FULL)
        else $error("instant ramp did not reach full level");
    slow_step_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (rise_len_i > 32'h0 && $stable(target_i))
        |=> ({1'b0, s.level} <= {1'b0, $past(s.level)} + 9'h001)
            || !target_i)
        else $error("ramp stepped by more than one count");
endmodule // lfs_ramp

// ---- logic/lfs_sequencer.sv ----
// sink b control sequencer: led mode, timed pulses, soft ramps
// Overview of operation
// - mode bit picks led or pulse operation
// - trigger select picks register bit or gpio
// - led mode: sink follows drive bit
// - drive rising edge starts one pulse
// - hardware clears drive after register pulse
// - pulse length set by length field only
// - gpio triggering ignores drive bit writes
// - repeat off: one pulse per trigger
// - repeat on: internal trigger every 4 s
// - length codes 32, 64, 96, 1024 ms
// - ramp codes: none, then per-mode lengths
`timescale 1ns/100ps
module lfs_sequencer #(
    parameter int unsigned PULSE_0_CYCLES = lfs_pkg::PULSE_0_CYC,
    parameter int unsigned PULSE_1_CYCLES = lfs_pkg::PULSE_1_CYC,
    parameter int unsigned PULSE_2_CYCLES = lfs_pkg::PULSE_2_CYC,
    parameter int unsigned PULSE_3_CYCLES = lfs_pkg::PULSE_3_CYC,
    parameter int unsigned LED_R1_CYCLES  = lfs_pkg::LED_RAMP_1_CYC,
    parameter int unsigned LED_R2_CYCLES  = lfs_pkg::LED_RAMP_2_CYC,
    parameter int unsigned LED_R3_CYCLES  = lfs_pkg::LED_RAMP_3_CYC,
    parameter int unsigned PLS_R1_CYCLES  = lfs_pkg::PLS_RAMP_1_CYC,
    parameter int unsigned PLS_R2_CYCLES  = lfs_pkg::PLS_RAMP_2_CYC,
    parameter int unsigned PLS_R3_CYCLES  = lfs_pkg::PLS_RAMP_3_CYC,
    parameter int unsigned REPEAT_CYCLES  = lfs_pkg::REPEAT_CYC
) (
    // clock and reset
    input  wire logic                        CLOCK_I,
    input  wire logic                        RST_B_I,
    // register port
    input  wire logic [lfs_pkg::ADDR_W-1:0]  REG_ADDR_I,
    input  wire logic [lfs_pkg::DATA_W-1:0]  REG_WDATA_I,
    input  wire logic                        REG_WR_I,
    input  wire logic                        REG_RD_I,
    output logic [lfs_pkg::DATA_W-1:0]       REG_RDATA_O,
    // trigger from the pin-function logic
    input  wire logic                        GPIO_PULSE_TRIG_I,
    // sink drive
    output logic                             SINK_B_ENABLE_O,
    output logic [lfs_pkg::LEVEL_W-1:0]      SINK_B_LEVEL_O,
    output logic                             PULSE_ACTIVE_O
);
    import lfs_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] rdata;
        logic              gpio_prev;
        logic              by_reg;
        lfs_state_t        state;
        logic [31:0]       pulse_cnt;
        logic [31:0]       rep_cnt;
    } lfs_seq_st_t;

    lfs_seq_st_t        s;
    lfs_seq_st_t        next_s;
    logic [LEVEL_W-1:0] level;
    logic               pulse_mode;
    logic               gpio_sel;
    logic               wr_ctrl;
    logic               reg_rise;
    logic               gpio_rise;
    logic               rep_tick;
    logic               trigger;
    logic               target;
    logic [31:0]        dur_cyc;
    logic [31:0]        rise_cyc;
    logic [31:0]        fall_cyc;

    // pulse length code to cycles
    function automatic logic [31:0] pulse_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: pulse_cycles = PULSE_0_CYCLES;
            2'h1: pulse_cycles = PULSE_1_CYCLES;
            2'h2: pulse_cycles = PULSE_2_CYCLES;
            2'h3: pulse_cycles = PULSE_3_CYCLES;
        endcase
    endfunction

    // ramp code to cycles, scaled by the active mode
    function automatic logic [31:0] ramp_cycles(input logic [1:0] code,
                                                input logic       pmode);
        unique case (code)
            2'h0: ramp_cycles = 32'h0000_0000;
            2'h1: ramp_cycles = pmode ? PLS_R1_CYCLES : LED_R1_CYCLES;
            2'h2: ramp_cycles = pmode ? PLS_R2_CYCLES : LED_R2_CYCLES;
            2'h3: ramp_cycles = pmode ? PLS_R3_CYCLES : LED_R3_CYCLES;
        endcase
    endfunction

    // field decode and trigger sources
    always_comb begin
        pulse_mode = s.ctrl[MODE_BIT];
        gpio_sel   = s.ctrl[TRIG_BIT];
        wr_ctrl    = REG_WR_I && (REG_ADDR_I == CTRL_ADDR);
        reg_rise   = wr_ctrl && REG_WDATA_I[DRIVE_BIT]
                     && !s.ctrl[DRIVE_BIT];
        gpio_rise  = GPIO_PULSE_TRIG_I && !s.gpio_prev;
        rep_tick   = pulse_mode && s.ctrl[RATE_BIT]
                     && (s.rep_cnt == REPEAT_CYCLES - 1);
        // trigger source, drive ignored when gpio selected
        trigger    = pulse_mode && (rep_tick
                     || (gpio_sel ? gpio_rise : reg_rise));
        dur_cyc    = pulse_cycles(s.ctrl[DUR_LSB +: 2]);
        rise_cyc   = ramp_cycles(s.ctrl[RISE_LSB +: 2], pulse_mode);
        fall_cyc   = ramp_cycles(s.ctrl[FALL_LSB +: 2], pulse_mode);
        // led mode follows drive, pulse mode follows pulse state
        target     = pulse_mode ? (s.state == LFS_PULSE)
                                : s.ctrl[DRIVE_BIT];
    end

    // next state of registers, pulse timer and repeat timer
    always_comb begin
        next_s           = s;
        next_s.gpio_prev = GPIO_PULSE_TRIG_I;
        next_s.rdata     = '0;
        // repeat timer runs only while repeat is enabled
        if (pulse_mode && s.ctrl[RATE_BIT]) begin
            next_s.rep_cnt = rep_tick ? 32'h0 : s.rep_cnt + 32'h1;
        end else begin
            next_s.rep_cnt = 32'h0;
        end
        unique case (s.state)
            LFS_IDLE: begin
                if (trigger) begin
                    next_s.state     = LFS_PULSE;
                    next_s.pulse_cnt = dur_cyc;
                    next_s.by_reg    = !gpio_sel;
                end
            end
            LFS_PULSE: begin
                if (!pulse_mode) begin
                    next_s.state     = LFS_IDLE;
                    next_s.pulse_cnt = 32'h0;
                end else if (s.pulse_cnt <= 32'h1) begin
                    next_s.state     = LFS_IDLE;
                    next_s.pulse_cnt = 32'h0;
                    if (s.by_reg) begin
                        next_s.ctrl[DRIVE_BIT] = 1'b0;
                    end
                end else begin
                    next_s.pulse_cnt = s.pulse_cnt - 32'h1;
                end
            end
        endcase
        // software write lands after the clear so a set wins
        if (wr_ctrl) begin
            next_s.ctrl = REG_WDATA_I & CTRL_MASK;
        end
        // read data stand one cycle after the strobe
        if (REG_RD_I) begin
            if (REG_ADDR_I == CTRL_ADDR) begin
                next_s.rdata = s.ctrl;
            end else if (REG_ADDR_I == STATUS_ADDR) begin
                next_s.rdata[STAT_PULSE]            = s.state == LFS_PULSE;
                next_s.rdata[STAT_ON]               = level != LEVEL_OFF;
                next_s.rdata[STAT_LVL_LSB +: LEVEL_W] = level;
            end
        end
    end

    // state register
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s       <= '0;
            s.ctrl  <= CTRL_RESET;
            s.state <= LFS_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // soft ramp on each on and off transition, one-step switch when the ramp code is zero
    lfs_ramp u_ramp (
        .clk_i      (CLOCK_I),
        .rst_b_i    (RST_B_I),
        .target_i   (target),
        .rise_len_i (rise_cyc),
        .fall_len_i (fall_cyc),
        .level_o    (level)
    );

    // outputs
    assign REG_RDATA_O     = s.rdata;
    assign SINK_B_LEVEL_O  = level;
    assign SINK_B_ENABLE_O = level != LEVEL_OFF;
    assign PULSE_ACTIVE_O  = s.state == LFS_PULSE;

    // led mode with no ramps tracks the drive bit
    led_follow_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (!pulse_mode && s.ctrl[RISE_LSB +: 2] == 2'h0
         && s.ctrl[FALL_LSB +: 2] == 2'h0 && !wr_ctrl)[*2]
        |-> SINK_B_ENABLE_O == s.ctrl[DRIVE_BIT])
        else $error("led mode sink does not follow drive bit");

    // register edge starts a pulse at once
    reg_start_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (pulse_mode && !gpio_sel && s.state == LFS_IDLE && reg_rise)
        |=> PULSE_ACTIVE_O && s.by_reg)
        else $error("register trigger did not start a pulse");

    // drive bit drops with the end of a register pulse
    drive_clear_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (s.state == LFS_PULSE && pulse_mode && s.by_reg
         && s.pulse_cnt == 32'h1 && !wr_ctrl)
        |=> !s.ctrl[DRIVE_BIT] && !PULSE_ACTIVE_O)
        else $error("drive bit not cleared after pulse");

    // pulse counter loads the decoded length
    pulse_len_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (s.state == LFS_IDLE && trigger)
        |=> s.pulse_cnt == $past(dur_cyc))
        else $error("pulse length not taken from field");

    // no gpio edge and no repeat tick, no pulse
    gpio_ignore_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (pulse_mode && gpio_sel && s.state == LFS_IDLE
         && !gpio_rise && !rep_tick)
        |=> !PULSE_ACTIVE_O)
        else $error("pulse started without gpio edge");

    // without repeat only a trigger starts a pulse
    single_shot_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (!s.ctrl[RATE_BIT] && s.state == LFS_IDLE && !trigger)
        |=> !PULSE_ACTIVE_O && s.rep_cnt == 32'h0)
        else $error("pulse without trigger");

    // repeat tick fires a pulse and restarts the timer
    repeat_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (rep_tick && s.state == LFS_IDLE)
        |=> PULSE_ACTIVE_O && s.rep_cnt == 32'h0)
        else $error("repeat tick did not fire pulse");

    // leaving pulse mode ends the pulse
    mode_abort_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (!pulse_mode && s.state == LFS_PULSE) |=> !PULSE_ACTIVE_O)
        else $error("pulse kept running in led mode");

    // longest length code
    len_code_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (s.ctrl[DUR_LSB +: 2] == 2'h3) |-> dur_cyc == PULSE_3_CYCLES)
        else $error("longest length code misdecoded");

    // led mode never runs the pulse timer
    led_no_pulse_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (!pulse_mode && s.state == LFS_IDLE) |=> !PULSE_ACTIVE_O)
        else $error("pulse started in led mode");

    // gpio edge starts a pulse that owns no drive bit
    gpio_start_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (pulse_mode && gpio_sel && s.state == LFS_IDLE && gpio_rise)
        |=> PULSE_ACTIVE_O && !s.by_reg)
        else $error("gpio edge did not start a pulse");

    // register source: gpio pin has no say
    reg_only_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (pulse_mode && !gpio_sel && s.state == LFS_IDLE
         && !reg_rise && !rep_tick) |=> !PULSE_ACTIVE_O)
        else $error("pulse started without register edge");

    // pulse runs on its counter, not on the trigger level
    pulse_hold_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (s.state == LFS_PULSE && pulse_mode && s.pulse_cnt > 32'h1)
        |=> PULSE_ACTIVE_O && s.pulse_cnt == $past(s.pulse_cnt) - 32'h1)
        else $error("pulse ended before its length");

    // gpio pulse leaves the drive bit alone
    gpio_drive_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (s.state == LFS_PULSE && !s.by_reg && !wr_ctrl)
        |=> s.ctrl[DRIVE_BIT] == $past(s.ctrl[DRIVE_BIT]))
        else $error("gpio pulse changed the drive bit");

    // repeat timer advances one count per cycle
    rep_count_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (pulse_mode && s.ctrl[RATE_BIT] && !rep_tick)
        |=> s.rep_cnt == $past(s.rep_cnt) + 32'h1)
        else $error("repeat timer did not advance");

    // pulse mode uses the short ramp lengths
    pulse_ramp_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (pulse_mode && s.ctrl[RISE_LSB +: 2] == 2'h3)
        |-> rise_cyc == PLS_R3_CYCLES)
        else $error("pulse mode ramp code misdecoded");

    // fall code zero switches the sink off in one step
    fall_apply_a: assert property (
        @(posedge CLOCK_I) disable iff (!RST_B_I)
        (!target && fall_cyc == 32'h0 && level != LEVEL_OFF)
        |=> level == LEVEL_OFF)
        else $error("instant fall did not switch sink off");
endmodule // lfs_sequencer

// ---- tb/lfs_sequencer_tb.sv ----
// self-checking bench for the sink b pulse sequencer
`timescale 1ns/100ps
module lfs_sequencer_tb;
    import lfs_pkg::*;
    // shortened cycle counts handed to the design
    localparam int unsigned RMP = 512;
    localparam int unsigned REP = 300;
    int unsigned plen [4] = '{20, 40, 60, 200};
    logic                clock_i = 1'b0;
    logic                rst_b   = 1'b0;
    logic [ADDR_W-1:0]   addr    = '0;
    logic [DATA_W-1:0]   wdata   = '0;
    logic                wr      = 1'b0;
    logic                rd      = 1'b0;
    logic                gpio    = 1'b0;
    logic [DATA_W-1:0]   rdata;
    logic                enable;
    logic [LEVEL_W-1:0]  level;
    logic                active;
    logic [DATA_W-1:0]   d;
    logic [DATA_W-1:0]   w;
    logic [31:0]         seed = 32'd57221;
    int                  error_cnt = 0;
    int                  checks = 0;
    int                  n;
    int                  g;

    lfs_sequencer #(
        .PULSE_0_CYCLES(20), .PULSE_1_CYCLES(40),
        .PULSE_2_CYCLES(60), .PULSE_3_CYCLES(200),
        .LED_R1_CYCLES(RMP), .LED_R2_CYCLES(2*RMP),
        .LED_R3_CYCLES(3*RMP), .PLS_R1_CYCLES(RMP),
        .PLS_R2_CYCLES(2*RMP), .PLS_R3_CYCLES(3*RMP),
        .REPEAT_CYCLES(REP)
    ) u_lfs_sequencer (
        .CLOCK_I(clock_i), .RST_B_I(rst_b), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .GPIO_PULSE_TRIG_I(gpio),
        .SINK_B_ENABLE_O(enable), .SINK_B_LEVEL_O(level),
        .PULSE_ACTIVE_O(active)
    );

    // 10 mhz clock
    always #50 clock_i = ~clock_i;

    // xorshift source of random register contents
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // compare one value and count it
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one-cycle register write
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clock_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd <= 1'b0;
        @(negedge clock_i);
        v = rdata;
    endtask

    // wait for a pulse start, then count its high cycles
    task automatic measure(input int maxw, output int wt, output int len);
        wt = 0;
        len = 0;
        // start off the edge so a just-launched output is settled
        @(negedge clock_i);
        while (active !== 1'b1 && wt < maxw) begin
            @(negedge clock_i);
            wt++;
        end
        while (active === 1'b1 && len < 5000) begin
            @(negedge clock_i);
            len++;
        end
    endtask

    // count cycles until the level reaches a value
    task automatic ramp_time(input logic [7:0] tgt, output int len);
        len = 0;
        while (level !== tgt && len < 4000) begin
            @(negedge clock_i);
            len++;
        end
    endtask

    // verdict and end of run
    task automatic test_done();
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // watchdog against a hung design
    initial begin
        repeat (40000) @(posedge clock_i);
        error_cnt++;
        $display("Error %0t: timeout", $time);
        test_done();
    end

    // main sequence
    initial begin
        repeat (4) @(posedge clock_i);
        rst_b <= 1'b1;
        // reset value, unmapped read and write
        reg_rd(CTRL_ADDR, d);
        chk(d, CTRL_RESET, "ctrl reset");
        @(negedge clock_i);
        chk(rdata, 16'h0000, "read data held past its cycle");
        reg_rd(8'h10, d);
        chk(d, 16'h0000, "unmapped read");
        reg_wr(8'h10, 16'hffff);
        reg_rd(CTRL_ADDR, d);
        chk(d, 16'h0000, "unmapped write");
        // random contents with mode and drive held low
        repeat (4) begin
            w = 16'(rnd()) & 16'h5fff;
            reg_wr(CTRL_ADDR, w);
            reg_rd(CTRL_ADDR, d);
            chk(d, w & CTRL_MASK, "ctrl readback");
        end
        reg_wr(CTRL_ADDR, 16'h2000);
        repeat (3) @(negedge clock_i);
        chk({7'h0, enable, level}, 16'h01ff, "led on");
        chk({15'h0, active}, 16'h0000, "led no pulse");
        reg_rd(STATUS_ADDR, d);
        chk(d, 16'hff02, "status led on");
        reg_wr(CTRL_ADDR, 16'h0000);
        repeat (3) @(negedge clock_i);
        chk({7'h0, enable, level}, 16'h0000, "led off");
        for (int c = 1; c <= 3; c++) begin
            reg_wr(CTRL_ADDR, 16'h2000 | 16'(c));
            ramp_time(8'hff, n);
            chk(16'(n > 255*2*c - 10 && n < 255*2*c + 10), 16'h1,
                "led rise time");
            reg_wr(CTRL_ADDR, 16'(c) << FALL_LSB);
            ramp_time(8'h00, n);
            chk(16'(n > 255*2*c - 10 && n < 255*2*c + 10), 16'h1,
                "led fall time");
        end
        for (int c = 0; c < 4; c++) begin
            // pulse mode is set first, drive rises in a later write
            reg_wr(CTRL_ADDR, 16'h8000 | (16'(c) << DUR_LSB));
            reg_wr(CTRL_ADDR, 16'ha000 | (16'(c) << DUR_LSB));
            measure(10, g, n);
            chk(16'(n), 16'(plen[c]), "pulse length");
            reg_rd(CTRL_ADDR, d);
            chk(d, 16'h8000 | (16'(c) << DUR_LSB), "drive clear");
        end
        // pulse ramps partly done after 20 cycles
        for (int c = 1; c <= 3; c++) begin
            reg_wr(CTRL_ADDR, 16'ha300 | 16'(c));
            repeat (20) @(negedge clock_i);
            chk(16'(level > 0 && level < 8'hff), 16'h1, "pulse ramp");
            measure(10, g, n);
        end
        reg_wr(CTRL_ADDR, 16'hc000);
        reg_wr(CTRL_ADDR, 16'he000);
        measure(20, g, n);
        chk(16'(n), 16'h0000, "drive ignored");
        // long gpio level gives one fixed pulse
        @(posedge clock_i);
        gpio <= 1'b1;
        measure(10, g, n);
        chk(16'(n), 16'(plen[0]), "gpio pulse");
        measure(100, g, n);
        chk(16'(n), 16'h0000, "single pulse");
        @(posedge clock_i);
        gpio <= 1'b0;
        reg_wr(CTRL_ADDR, 16'hd000);
        measure(REP + 20, g, n);
        chk(16'(n), 16'(plen[0]), "repeat first");
        measure(REP + 20, g, n);
        chk(16'(g + plen[0] > REP - 3 && g + plen[0] < REP + 3), 16'h1,
            "repeat period");
        reg_wr(CTRL_ADDR, 16'h0000);
        test_done();
    end
endmodule // lfs_sequencer_tb
